//--- rtl/pscr_pkg.sv
// package: constants and types of the status/command configuration register
package pscr_pkg;

  // configuration space byte offset of the status/command word
  localparam logic [7:0]  PSCR_OFF_STATCMD   = 8'h04;

  // status half, sticky error bits and fixed fields
  localparam int          PSCR_BIT_DET_PERR  = 31;  // detected_parity_error
  localparam int          PSCR_BIT_SIG_SERR  = 30;  // signaled_system_error
  localparam int          PSCR_BIT_RCV_MABT  = 29;  // received_master_abort
  localparam int          PSCR_BIT_RCV_TABT  = 28;  // received_target_abort
  localparam int          PSCR_BIT_STA       = 27;  // signalled target abort, fixed 0
  localparam int          PSCR_BIT_DEVSEL_LO = 25;  // devsel timing field, low bit
  localparam int          PSCR_BIT_DATA_PERR = 24;  // data_parity_error_seen
  localparam int          PSCR_BIT_FBBC      = 23;  // fast back-to-back capable, fixed 1
  localparam int          PSCR_BIT_UDF       = 22;  // udf supported, fixed 0
  localparam int          PSCR_BIT_66MHZ     = 21;  // 66 mhz capable, fixed 0

  // command half, writable bits and fixed-zero bits
  localparam int          PSCR_BIT_FB2B_EN   = 9;   // fast_b2b_enable
  localparam int          PSCR_BIT_SERR_EN   = 8;   // system_error_driver_enable
  localparam int          PSCR_BIT_WAIT      = 7;   // wait cycle control, fixed 0
  localparam int          PSCR_BIT_PERR_RSP  = 6;   // parity_error_response
  localparam int          PSCR_BIT_VGA       = 5;   // vga palette snoop, fixed 0
  localparam int          PSCR_BIT_MWI       = 4;   // write and invalidate, fixed 0
  localparam int          PSCR_BIT_SPCYC_EN  = 3;   // special_cycle_enable
  localparam int          PSCR_BIT_MST_EN    = 2;   // bus_master_enable
  localparam int          PSCR_BIT_MEM_EN    = 1;   // memory_space_enable
  localparam int          PSCR_BIT_IO_EN     = 0;   // io_space_enable

  // fixed field values
  localparam logic [1:0]  PSCR_DEVSEL_TIMING = 2'h1;          // medium decode
  localparam logic [31:0] PSCR_RESET_VALUE   = 32'h0280_0000;
  localparam logic [31:0] PSCR_FIXED_ONES    = 32'h0280_0000; // bits 25 and 23
  localparam logic [15:0] PSCR_CMD_RESET     = 16'h0000;

  // number of sticky status bits and their slot in the status vector
  localparam int          PSCR_NUM_STICKY    = 5;
  localparam int          PSCR_IDX_DATA_PERR = 0;
  localparam int          PSCR_IDX_RCV_TABT  = 1;
  localparam int          PSCR_IDX_RCV_MABT  = 2;
  localparam int          PSCR_IDX_SIG_SERR  = 3;
  localparam int          PSCR_IDX_DET_PERR  = 4;

  // clocks from address phase to device select for medium decode
  localparam int          PSCR_DEVSEL_CYCLES = 2;

  // configuration access sequencer
  typedef enum logic [2:0] {
    PSCR_IDLE = 3'b001,   // waiting for an address phase
    PSCR_DEC  = 3'b010,   // decode clock, device select not yet driven
    PSCR_CLM  = 3'b100    // device select driven, data phase
  } pscr_state_t;

endpackage : pscr_pkg

//--- rtl/pscr_status_command.sv
// module: status/command register of the configuration header with its access port
`timescale 1ns/1ns
// Contract
// RULE1: parity error always sets detected parity flag
// RULE2: system error flag needs driver enable plus cause
// RULE3: own master abort sets received master abort
// RULE4: target abort received sets its flag
// RULE5: never signal target abort, bit reads zero
// RULE6: medium decode, timing field reads 01
// RULE7: data parity flag: perr, master, response
// RULE8: fast back-to-back capable reads one
// RULE9: 66 mhz capable reads zero
// RULE10: udf, vga, reserved ranges read zero
// RULE11: no stepping, wait control reads zero
// RULE12: write and invalidate enable reads zero
// RULE13: fast b2b enable allows different agents
// RULE14: serr driven only with driver enable
// RULE15: parity response gates parity actions
// RULE16: special cycle bit writable, no effect
// RULE17: mastering only with bus master enable
// RULE18: host sets bus master before requests
// RULE19: memory response only with memory enable
// RULE20: host sets memory enable before access
// RULE21: io space bit writable, no effect
// RULE22: constant bits hardwired, writes ignored
// RULE23: reached only by configuration cycles
// RULE24: error flags cleared by writing one
module pscr_status_command
  import pscr_pkg::*;
(
  input  wire logic        CLOCK,
  input  wire logic        RSTN,
  // configuration access port
  input  wire logic        CFG_START,
  input  wire logic        CFG_IDSEL,
  input  wire logic        CFG_WRITE,
  input  wire logic [7:0]  CFG_OFFSET,
  input  wire logic [3:0]  CFG_BE_N,
  input  wire logic [31:0] CFG_WDATA,
  output logic             CFG_DEVSEL_N,
  output logic [31:0]      CFG_RDATA,
  // events reported by the bus engine, one-cycle pulses
  input  wire logic        EV_PARITY_ERR,
  input  wire logic        EV_ADDR_PARITY,
  input  wire logic        EV_PERR_AS_MASTER,
  input  wire logic        EV_MASTER_ABORT,
  input  wire logic        EV_TARGET_ABORT,
  // requests from the bus engine, gated by the command bits
  input  wire logic        MST_REQ,
  input  wire logic        MEM_HIT,
  input  wire logic        B2B_DIFF_REQ,
  // gated results and command levels
  output logic             MST_START,
  output logic             MEM_CLAIM,
  output logic             B2B_DIFF_OK,
  output logic             PARITY_ACTION,
  output logic             SERR_O,
  output logic             SERR_OE,
  output logic             BUS_MASTER_EN,
  output logic             MEMORY_SPACE_EN
);

  import pscr_pkg::*;
  // command bits
  logic        fast_b2b_enable_reg;             // fast_b2b_enable
  logic        fast_b2b_enable_next;
  logic        system_error_driver_enable_reg;  // system_error_driver_enable
  logic        system_error_driver_enable_next;
  logic        parity_error_response_reg;       // parity_error_response
  logic        parity_error_response_next;
  logic        special_cycle_enable_reg;        // special_cycle_enable
  logic        special_cycle_enable_next;
  logic        bus_master_enable_reg;           // bus_master_enable
  logic        bus_master_enable_next;
  logic        memory_space_enable_reg;         // memory_space_enable
  logic        memory_space_enable_next;
  logic        io_space_enable_reg;             // io_space_enable
  logic        io_space_enable_next;

  // access sequencer and latched request
  pscr_state_t state_reg;        // sequencer state
  pscr_state_t state_next;
  logic        wr_reg;           // latched write flag
  logic        wr_next;
  logic [7:0]  off_reg;          // latched byte offset
  logic [7:0]  off_next;
  logic [3:0]  be_n_reg;         // latched byte enables, active low
  logic [3:0]  be_n_next;
  logic [31:0] wdata_reg;        // latched write data
  logic [31:0] wdata_next;
  logic        devsel_n_reg;     // device select, active low
  logic        devsel_n_next;
  logic [31:0] rdata_reg;        // read data
  logic [31:0] rdata_next;

  // gated outputs
  logic        mst_start_reg;
  logic        mst_start_next;
  logic        mem_claim_reg;
  logic        mem_claim_next;
  logic        b2b_diff_ok_reg;
  logic        b2b_diff_ok_next;
  logic        parity_action_reg;
  logic        parity_action_next;
  logic        serr_oe_reg;
  logic        serr_oe_next;

  // status flags
  logic [PSCR_NUM_STICKY-1:0] st_set;   // hardware set requests
  logic [PSCR_NUM_STICKY-1:0] st_clr;   // software write-one clears
  logic [PSCR_NUM_STICKY-1:0] st_q;     // flag values
  logic        taken;                    // address phase accepted
  logic        hit_word;                 // data phase hits this word
  logic        do_write;                 // write applies this clock
  logic        sys_err_cause;            // any system error cause
  logic [31:0] reg_value;                // assembled read value

  // an address phase is accepted only with idsel in idle
  assign taken    = CFG_START && CFG_IDSEL && (state_reg == PSCR_IDLE);  // RULE23
  assign hit_word = (off_reg[7:2] == PSCR_OFF_STATCMD[7:2]);
  // writes land on the clock that drives device select low
  assign do_write = (state_reg == PSCR_DEC) && wr_reg && hit_word;

  // system error causes, address parity only counts with response on
  assign sys_err_cause = EV_MASTER_ABORT || EV_TARGET_ABORT ||
                         (EV_ADDR_PARITY && parity_error_response_reg);  // RULE2 RULE15

  // set conditions of the sticky flags
  always_comb begin
    st_set                     = '0;
    st_set[PSCR_IDX_DET_PERR]  = EV_PARITY_ERR;                                   // RULE1
    st_set[PSCR_IDX_SIG_SERR]  = system_error_driver_enable_reg && sys_err_cause; // RULE2
    st_set[PSCR_IDX_RCV_MABT]  = EV_MASTER_ABORT;                                 // RULE3
    st_set[PSCR_IDX_RCV_TABT]  = EV_TARGET_ABORT;                                 // RULE4
    st_set[PSCR_IDX_DATA_PERR] = EV_PERR_AS_MASTER && parity_error_response_reg;  // RULE7
  end

  // write-one clears, only through the top byte lane
  always_comb begin
    st_clr = '0;
    if (do_write && !be_n_reg[3]) begin
      st_clr[PSCR_IDX_DET_PERR]  = wdata_reg[PSCR_BIT_DET_PERR];   // RULE24
      st_clr[PSCR_IDX_SIG_SERR]  = wdata_reg[PSCR_BIT_SIG_SERR];   // RULE24
      st_clr[PSCR_IDX_RCV_MABT]  = wdata_reg[PSCR_BIT_RCV_MABT];   // RULE24
      st_clr[PSCR_IDX_RCV_TABT]  = wdata_reg[PSCR_BIT_RCV_TABT];   // RULE24
      st_clr[PSCR_IDX_DATA_PERR] = wdata_reg[PSCR_BIT_DATA_PERR];  // RULE24
    end
  end

  // one sticky flag per error status bit
  genvar gi;
  generate
    for (gi = 0; gi < PSCR_NUM_STICKY; gi++) begin : g_sticky
      pscr_sticky_bit u_bit (
        .CLOCK  (CLOCK),
        .RSTN   (RSTN),
        .SET_IN (st_set[gi]),
        .CLR_IN (st_clr[gi]),
        .Q      (st_q[gi])
      );
    end
  endgenerate

  // read value: fixed pattern with live flags and command bits
  always_comb begin
    reg_value                      = PSCR_FIXED_ONES;  // RULE6 RULE8 RULE22
    reg_value[PSCR_BIT_STA]        = 1'b0;             // RULE5
    reg_value[PSCR_BIT_66MHZ]      = 1'b0;             // RULE9
    reg_value[PSCR_BIT_UDF]        = 1'b0;             // RULE10
    reg_value[PSCR_BIT_WAIT]       = 1'b0;             // RULE11
    reg_value[PSCR_BIT_MWI]        = 1'b0;             // RULE12
    reg_value[PSCR_BIT_VGA]        = 1'b0;             // RULE10
    reg_value[PSCR_BIT_DEVSEL_LO +: 2] = PSCR_DEVSEL_TIMING;  // RULE6
    reg_value[PSCR_BIT_DET_PERR]   = st_q[PSCR_IDX_DET_PERR];
    reg_value[PSCR_BIT_SIG_SERR]   = st_q[PSCR_IDX_SIG_SERR];
    reg_value[PSCR_BIT_RCV_MABT]   = st_q[PSCR_IDX_RCV_MABT];
    reg_value[PSCR_BIT_RCV_TABT]   = st_q[PSCR_IDX_RCV_TABT];
    reg_value[PSCR_BIT_DATA_PERR]  = st_q[PSCR_IDX_DATA_PERR];
    reg_value[PSCR_BIT_FB2B_EN]    = fast_b2b_enable_reg;
    reg_value[PSCR_BIT_SERR_EN]    = system_error_driver_enable_reg;
    reg_value[PSCR_BIT_PERR_RSP]   = parity_error_response_reg;
    reg_value[PSCR_BIT_SPCYC_EN]   = special_cycle_enable_reg;
    reg_value[PSCR_BIT_MST_EN]     = bus_master_enable_reg;
    reg_value[PSCR_BIT_MEM_EN]     = memory_space_enable_reg;
    reg_value[PSCR_BIT_IO_EN]      = io_space_enable_reg;
  end

  // next command bits, only writable positions follow the byte lanes
  always_comb begin
    fast_b2b_enable_next            = fast_b2b_enable_reg;
    system_error_driver_enable_next = system_error_driver_enable_reg;
    parity_error_response_next      = parity_error_response_reg;
    special_cycle_enable_next       = special_cycle_enable_reg;
    bus_master_enable_next          = bus_master_enable_reg;
    memory_space_enable_next        = memory_space_enable_reg;
    io_space_enable_next            = io_space_enable_reg;
    if (do_write && !be_n_reg[1]) begin
      fast_b2b_enable_next            = wdata_reg[PSCR_BIT_FB2B_EN];
      system_error_driver_enable_next = wdata_reg[PSCR_BIT_SERR_EN];
    end
    if (do_write && !be_n_reg[0]) begin
      parity_error_response_next = wdata_reg[PSCR_BIT_PERR_RSP];
      special_cycle_enable_next  = wdata_reg[PSCR_BIT_SPCYC_EN];  // RULE16
      bus_master_enable_next     = wdata_reg[PSCR_BIT_MST_EN];
      memory_space_enable_next   = wdata_reg[PSCR_BIT_MEM_EN];
      io_space_enable_next       = wdata_reg[PSCR_BIT_IO_EN];     // RULE21
    end
  end

  // command bit registers
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      fast_b2b_enable_reg            <= PSCR_CMD_RESET[PSCR_BIT_FB2B_EN];
      system_error_driver_enable_reg <= PSCR_CMD_RESET[PSCR_BIT_SERR_EN];
      parity_error_response_reg      <= PSCR_CMD_RESET[PSCR_BIT_PERR_RSP];
      special_cycle_enable_reg       <= PSCR_CMD_RESET[PSCR_BIT_SPCYC_EN];
      bus_master_enable_reg          <= PSCR_CMD_RESET[PSCR_BIT_MST_EN];
      memory_space_enable_reg        <= PSCR_CMD_RESET[PSCR_BIT_MEM_EN];
      io_space_enable_reg            <= PSCR_CMD_RESET[PSCR_BIT_IO_EN];
    end else begin
      fast_b2b_enable_reg            <= fast_b2b_enable_next;
      system_error_driver_enable_reg <= system_error_driver_enable_next;
      parity_error_response_reg      <= parity_error_response_next;
      special_cycle_enable_reg       <= special_cycle_enable_next;
      bus_master_enable_reg          <= bus_master_enable_next;
      memory_space_enable_reg        <= memory_space_enable_next;
      io_space_enable_reg            <= io_space_enable_next;
    end
  end

  // sequencer: medium decode drives device select on the second clock
  always_comb begin
    state_next    = state_reg;
    wr_next       = wr_reg;
    off_next      = off_reg;
    be_n_next     = be_n_reg;
    wdata_next    = wdata_reg;
    devsel_n_next = 1'b1;
    rdata_next    = rdata_reg;
    case (state_reg)
      PSCR_IDLE: begin
        // latch the request on the address phase
        if (taken) begin
          wr_next    = CFG_WRITE;
          off_next   = CFG_OFFSET;
          be_n_next  = CFG_BE_N;
          wdata_next = CFG_WDATA;
          state_next = PSCR_DEC;
        end
      end
      PSCR_DEC: begin
        // claim every offset of the space, other words read zero
        devsel_n_next = 1'b0;  // RULE6 RULE23
        rdata_next    = (hit_word && !wr_reg) ? reg_value : '0;
        state_next    = PSCR_CLM;
      end
      PSCR_CLM: begin
        // data phase done, back to idle
        state_next = PSCR_IDLE;
      end
      default: begin
        state_next = PSCR_IDLE;
      end
    endcase
  end

  // sequencer registers
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      state_reg    <= PSCR_IDLE;
      wr_reg       <= 1'b0;
      off_reg      <= 8'h00;
      be_n_reg     <= 4'hf;
      wdata_reg    <= 32'h0000_0000;
      devsel_n_reg <= 1'b1;
      rdata_reg    <= 32'h0000_0000;
    end else begin
      state_reg    <= state_next;
      wr_reg       <= wr_next;
      off_reg      <= off_next;
      be_n_reg     <= be_n_next;
      wdata_reg    <= wdata_next;
      devsel_n_reg <= devsel_n_next;
      rdata_reg    <= rdata_next;
    end
  end

  // gated requests and driver enables for the bus engine
  always_comb begin
    mst_start_next     = MST_REQ && bus_master_enable_reg;                    // RULE17
    mem_claim_next     = MEM_HIT && memory_space_enable_reg;                  // RULE19
    b2b_diff_ok_next   = B2B_DIFF_REQ && fast_b2b_enable_reg;                 // RULE13
    parity_action_next = EV_PARITY_ERR && parity_error_response_reg;          // RULE15
    serr_oe_next       = system_error_driver_enable_reg && sys_err_cause;     // RULE14
  end

  // gated output registers
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      mst_start_reg     <= 1'b0;
      mem_claim_reg     <= 1'b0;
      b2b_diff_ok_reg   <= 1'b0;
      parity_action_reg <= 1'b0;
      serr_oe_reg       <= 1'b0;
    end else begin
      mst_start_reg     <= mst_start_next;
      mem_claim_reg     <= mem_claim_next;
      b2b_diff_ok_reg   <= b2b_diff_ok_next;
      parity_action_reg <= parity_action_next;
      serr_oe_reg       <= serr_oe_next;
    end
  end

  // port drive, all from flip-flops except the constant SERR_O
  assign CFG_DEVSEL_N    = devsel_n_reg;
  assign CFG_RDATA       = rdata_reg;
  assign MST_START       = mst_start_reg;
  assign MEM_CLAIM       = mem_claim_reg;
  assign B2B_DIFF_OK     = b2b_diff_ok_reg;
  assign PARITY_ACTION   = parity_action_reg;
  assign SERR_O          = 1'b0;  // open drain, only pulls low
  assign SERR_OE         = serr_oe_reg;
  assign BUS_MASTER_EN   = bus_master_enable_reg;
  assign MEMORY_SPACE_EN = memory_space_enable_reg;

  // checks
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RSTN);
  // address phase accepted, then two clocks to device select
  sequence s_taken;
    CFG_START && CFG_IDSEL && (state_reg == PSCR_IDLE);
  endsequence
  sequence s_claim;
    !CFG_DEVSEL_N ##1 CFG_DEVSEL_N;
  endsequence
  sequence s_read_self;
    s_taken ##0 (!CFG_WRITE && (CFG_OFFSET[7:2] == PSCR_OFF_STATCMD[7:2]));
  endsequence
  chk_devsel_medium: assert property (s_taken |-> CFG_DEVSEL_N ##1 CFG_DEVSEL_N ##1 s_claim)  // RULE6
    else $error("device select not on second clock after address phase");
  chk_idsel_needed: assert property (!CFG_DEVSEL_N |-> $past(state_reg, 1) == PSCR_DEC)  // RULE23
    else $error("device select without a decoded configuration cycle");
  chk_fixed_bits: assert property (s_read_self |-> ##2
      (CFG_RDATA[27:25] == 3'h1) && (CFG_RDATA[23:21] == 3'h4) && (CFG_RDATA[20:10] == 11'h000) &&
      (CFG_RDATA[7] == 1'b0) && (CFG_RDATA[5:4] == 2'h0))  // RULE22
    else $error("hardwired bits read wrong");
  chk_dpe_sticky: assert property (EV_PARITY_ERR |=> st_q[PSCR_IDX_DET_PERR])  // RULE1
    else $error("detected parity flag not set");
  chk_sse_cause: assert property ($rose(st_q[PSCR_IDX_SIG_SERR]) |->
      $past(system_error_driver_enable_reg) && $past(sys_err_cause))  // RULE2
    else $error("system error flag set without enabled cause");
  chk_rma_set: assert property (EV_MASTER_ABORT |=> st_q[PSCR_IDX_RCV_MABT])  // RULE3
    else $error("master abort flag not set");
  chk_rta_set: assert property (EV_TARGET_ABORT |=> st_q[PSCR_IDX_RCV_TABT])  // RULE4
    else $error("target abort flag not set");
  chk_data_parity_error_seen_cause: assert property ($rose(st_q[PSCR_IDX_DATA_PERR]) |->
      $past(EV_PERR_AS_MASTER) && $past(parity_error_response_reg))  // RULE7
    else $error("data parity flag set without cause");
  chk_serr_gate: assert property (SERR_OE |-> $past(system_error_driver_enable_reg))  // RULE14
    else $error("serr driven while driver disabled");
  chk_mst_gate: assert property (MST_START |-> $past(MST_REQ) && $past(bus_master_enable_reg))  // RULE17
    else $error("master start without bus master enable");
  chk_mem_gate: assert property (MEM_CLAIM |-> $past(MEM_HIT) && $past(memory_space_enable_reg))  // RULE19
    else $error("memory claim without memory space enable");
  chk_w1c_clear: assert property ((st_clr[PSCR_IDX_RCV_MABT] && !st_set[PSCR_IDX_RCV_MABT]) |=>
      !st_q[PSCR_IDX_RCV_MABT])  // RULE24
    else $error("write one did not clear master abort flag");

endmodule : pscr_status_command

//--- rtl/pscr_sticky_bit.sv
// module: one sticky status flag, hardware sets it, a written one clears it
`timescale 1ns/1ns
module pscr_sticky_bit (
  input  wire logic CLOCK,
  input  wire logic RSTN,
  input  wire logic SET_IN,
  input  wire logic CLR_IN,
  output logic      Q
);

  logic q_reg;   // flag state
  logic q_next;  // flag next value

  // a set in the clearing cycle wins so no event is lost
  always_comb begin
    q_next = q_reg;
    if (CLR_IN) begin
      q_next = 1'b0;
    end
    if (SET_IN) begin
      q_next = 1'b1;
    end
  end

  // flag register
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      q_reg <= 1'b0;
    end else begin
      q_reg <= q_next;
    end
  end

  assign Q = q_reg;

endmodule : pscr_sticky_bit

//--- verif/pscr_engine_model.sv
// model: bus engine that raises requests once the host has enabled the device
`timescale 1ns/1ns
module pscr_engine_model (
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic [2:0] want,  // bit0 master, bit1 memory hit, bit2 b2b other agent
  input  wire logic       bm_en,
  input  wire logic       ms_en,
  output logic            mst_req,
  output logic            mem_hit,
  output logic            b2b_req
);
  logic bm_armed;  // bus master enable seen since reset
  logic ms_armed;  // memory enable seen since reset
  // requests move on the falling edge, only once the matching enable was set
  always @(negedge clk or negedge rstn) begin
    if (!rstn) begin
      {bm_armed, ms_armed, mst_req, mem_hit, b2b_req} <= '0;
    end else begin
      bm_armed <= bm_armed | bm_en;
      ms_armed <= ms_armed | ms_en;
      mst_req  <= want[0] & (bm_armed | bm_en);
      mem_hit  <= want[1] & (ms_armed | ms_en);
      b2b_req  <= want[2] & (bm_armed | bm_en);
    end
  end
endmodule : pscr_engine_model

//--- verif/pscr_status_command_test.sv
// testbench: configuration access and event checks of the status/command register
`timescale 1ns/1ns
module pscr_status_command_test;
  import pscr_pkg::*;
  logic        clk = 1'b0, rstn = 1'b0, start = 1'b0, idsel = 1'b0, wr = 1'b0;
  logic [7:0]  off = '0;
  logic [3:0]  ben = '0;
  logic [31:0] wd = '0, rd, rdata;
  logic [4:0]  ev = '0;    // parity, addr parity, perr as master, master abort, target abort
  logic [2:0]  want = '0;  // requests asked of the engine model
  logic        devsel_n, pa, serr_o, serr_oe, bm_en, ms_en, mst, mem, b2b, mreq, mhit, breq;
  logic        pa_seen, oe_seen;
  int          fails = 0, total_checks = 0;
  // clock generator, 20 ns period
  initial forever #10 clk = ~clk;
  pscr_status_command dut_u (.CLOCK(clk), .RSTN(rstn), .CFG_START(start), .CFG_IDSEL(idsel),
    .CFG_WRITE(wr), .CFG_OFFSET(off), .CFG_BE_N(ben), .CFG_WDATA(wd), .CFG_DEVSEL_N(devsel_n),
    .CFG_RDATA(rdata), .EV_PARITY_ERR(ev[4]), .EV_ADDR_PARITY(ev[3]), .EV_PERR_AS_MASTER(ev[2]),
    .EV_MASTER_ABORT(ev[1]), .EV_TARGET_ABORT(ev[0]), .MST_REQ(mreq), .MEM_HIT(mhit),
    .B2B_DIFF_REQ(breq), .MST_START(mst), .MEM_CLAIM(mem), .B2B_DIFF_OK(b2b), .PARITY_ACTION(pa),
    .SERR_O(serr_o), .SERR_OE(serr_oe), .BUS_MASTER_EN(bm_en), .MEMORY_SPACE_EN(ms_en));
  pscr_engine_model eng_u (.clk(clk), .rstn(rstn), .want(want), .bm_en(bm_en), .ms_en(ms_en),
    .mst_req(mreq), .mem_hit(mhit), .b2b_req(breq));
  // word compare
  task automatic chk32(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk32
  // flag compare
  task automatic chk1(input string nm, input logic e, input logic g);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("Error %s expected %b seen %b", nm, e, g);
    end
  endtask : chk1
  // one configuration cycle, held until device select answers in cycle 2
  task automatic cfg(input logic w, input logic [7:0] o, input logic [31:0] d, output logic [31:0] r);
    int n;
    @(negedge clk);
    {start, idsel, wr, off, ben, wd} = {2'b11, w, o, 4'h0, d};
    @(negedge clk);
    start = 0;
    for (n = 0; n < 4 && devsel_n !== 1'b0; n++) @(negedge clk);
    chk1("devsel in cycle 2", 1'b1, n == 1);
    r = rdata;
    idsel = 0;
  endtask : cfg
  // one event pulse, then watch the gated outputs for two cycles
  task automatic pulse(input logic [4:0] v);
    @(negedge clk);
    ev = v;
    @(negedge clk);
    ev = '0;
    {pa_seen, oe_seen} = {pa, serr_oe};
    @(negedge clk);
    {pa_seen, oe_seen} = {pa_seen | pa, oe_seen | serr_oe};
    chk1("serr value", 1'b0, serr_o);
  endtask : pulse
  // requests from the engine model, checked a few cycles later
  task automatic req(input logic [2:0] w, input logic [2:0] e);
    @(negedge clk);
    want = w;
    repeat (4) @(negedge clk);
    chk32("gated requests", {29'h0, e}, {29'h0, b2b, mem, mst});
  endtask : req
  // verdict
  task automatic results;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : results
  // watchdog
  initial begin
    #100000;
    fails++;
    results;
  end
  // main sequence
  initial begin
    repeat (10) @(negedge clk);
    rstn = 1;
    cfg(0, PSCR_OFF_STATCMD, 32'h0, rd);
    chk32("reset value", PSCR_RESET_VALUE, rd);
    req(3'h7, 3'h0);
    cfg(1, PSCR_OFF_STATCMD, 32'hffff_ffff, rd);
    cfg(0, PSCR_OFF_STATCMD, 32'h0, rd);
    chk32("all ones written", 32'h0280_034f, rd);
    chk1("bm level", 1'b1, bm_en & ms_en);
    req(3'h7, 3'h7);
    pulse(5'b10000);
    chk32("parity gated", 32'h2, {30'h0, pa_seen, oe_seen});
    pulse(5'b00010);
    chk1("serr on abort", 1'b1, oe_seen);
    pulse(5'b00001);
    pulse(5'b00100);
    cfg(0, PSCR_OFF_STATCMD, 32'h0, rd);
    chk32("errors set", 32'hf380_034f, rd);
    cfg(1, PSCR_OFF_STATCMD, 32'h8000_034f, rd);
    cfg(0, PSCR_OFF_STATCMD, 32'h0, rd);
    chk32("one bit cleared", 32'h7380_034f, rd);
    cfg(1, PSCR_OFF_STATCMD, 32'h7100_034f, rd);
    pulse(5'b11000);
    cfg(0, PSCR_OFF_STATCMD, 32'h0, rd);
    chk32("addr parity", 32'hc280_034f, rd);
    cfg(1, PSCR_OFF_STATCMD, 32'hc000_000e, rd);
    pulse(5'b10110);
    chk32("responses off", 32'h0, {30'h0, pa_seen, oe_seen});
    cfg(0, PSCR_OFF_STATCMD, 32'h0, rd);
    chk32("errors gated", 32'ha280_000e, rd);
    req(3'h7, 3'h3);
    cfg(1, PSCR_OFF_STATCMD, 32'h0, rd);
    req(3'h7, 3'h0);
    @(negedge clk);
    {start, idsel} = 2'b10;
    @(negedge clk);
    start = 0;
    repeat (4) @(negedge clk) chk1("unselected devsel", 1'b1, devsel_n);
    cfg(0, 8'h08, 32'h0, rd);
    chk32("other offset", 32'h0, rd);
    results;
  end
endmodule : pscr_status_command_test
